// ### logic/wsp_regs.svh
// Register offsets, field positions, reset values and timing for the sequence player
`ifndef WSP_REGS_SVH
`define WSP_REGS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define WSP_OFF_CTRL   8'h00
`define WSP_OFF_CFG    8'h04
`define WSP_OFF_RATE   8'h08
`define WSP_OFF_COUNT  8'h0C
`define WSP_OFF_TIDX   8'h10
`define WSP_OFF_TSEL   8'h14
`define WSP_OFF_TLEN   8'h18
`define WSP_OFF_TREP   8'h1C
`define WSP_OFF_WADDR  8'h20
`define WSP_OFF_WDATA  8'h24
`define WSP_OFF_STAT   8'h28

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define WSP_CTRL_EXEC  0
`define WSP_CTRL_MTRIG 1
`define WSP_CTRL_STOP  2
`define WSP_CFG_TMODE  2
`define WSP_CFG_EDGE   3
`define WSP_CFG_SMODE  4

// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define WSP_CFG_RST    5'h00
`define WSP_RATE_RST   32'h000F4240
`define WSP_COUNT_RST  11'h001
`define WSP_COUNT_MAX  11'h400
`define WSP_CLK_HZ     32'h02625A00

`endif

// ### logic/wsp_pkg.sv
// Types shared by the waveform sequence player
package wsp_pkg;
    typedef enum logic [1:0] {
        WSP_IDLE = 2'b00,
        WSP_WAIT = 2'b01,
        WSP_PLAY = 2'b10
    } wsp_state_t;

    typedef enum logic [1:0] {
        WSP_SRC_INT = 2'b00,
        WSP_SRC_MAN = 2'b01,
        WSP_SRC_EXT = 2'b10
    } wsp_src_t;

    typedef logic [3:0]  wsp_sel_t;
    typedef logic [14:0] wsp_len_t;
    typedef logic [15:0] wsp_rep_t;
    typedef logic [9:0]  wsp_idx_t;
    typedef logic [10:0] wsp_cnt_t;
    typedef logic [17:0] wsp_waddr_t;
    typedef logic [15:0] wsp_smp_t;
endpackage

// ### logic/wsp_trig_sync.sv
// Trigger input synchroniser with selectable edge detect
`timescale 1ns/1ps
module wsp_trig_sync
(
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic trig_in,
    input  wire logic falling_in,
    output logic      pulse_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // Two stages, then a third for the edge; only s2 and s3 feed logic
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            pulse_out <= 1'b0;
        end
        else if (ce_in)
        begin
            s1_reg    <= trig_in;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            pulse_out <= falling_in ? (s3_reg & ~s2_reg) : (~s3_reg & s2_reg); // RL13 RL21
        end
    end
endmodule

// ### logic/wsp_wave_mem.sv
// Built-in waveform store: 16 waveforms of 16384 points each
`timescale 1ns/1ps
module wsp_wave_mem
(
    input  wire logic                 mclk_in,
    input  wire logic                 rst_in,
    input  wire logic                 ce_in,
    input  wire logic                 we_in,
    input  wire wsp_pkg::wsp_waddr_t  waddr_in,
    input  wire wsp_pkg::wsp_smp_t    wdata_in,
    input  wire wsp_pkg::wsp_waddr_t  raddr_in,
    output wsp_pkg::wsp_smp_t         rdata_out
);
    wsp_pkg::wsp_smp_t mem [0:262143];

    // Write port, no reset: contents are volatile
    always_ff @(posedge mclk_in)
    begin
        if (ce_in && we_in)
            mem[waddr_in] <= wdata_in;
    end

    // Registered read, one cycle latency
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            rdata_out <= 16'h0000;
        else if (ce_in)
            rdata_out <= mem[raddr_in];
    end
endmodule

// ### logic/wsp_player.sv
// Waveform sequence player: APB registers, sequence table, trigger and sync logic
//
// What this block does
// RL1 - Table of 1024 entries: wave, length, repeats
// RL2 - Samples always fetched from built-in wave store
// RL3 - Play length, repeat count times, in order
// RL4 - One sample per programmable sample-rate tick
// RL5 - Pass time is sum of length/rate times repeats
// RL6 - Execute starts the programmed sequence
// RL7 - Internal source replays without any trigger
// RL8 - Each manual trigger gives one output step
// RL9 - Each active external edge gives one step
// RL10 - Trigger mode ignored under internal source
// RL11 - Entry mode: one trigger plays whole entry
// RL12 - Cycle mode: one trigger plays one cycle
// RL13 - Selectable rising or falling external edge
// RL14 - Entry sync: one pulse per entry
// RL15 - Cycle sync: one pulse per played cycle
// RL16 - Sync rises at each entry switch-over
// RL17 - Entry sync high for half the repeats
// RL18 - Triggered sync follows trigger events
// RL19 - Table held in volatile memory
// RL20 - Programmable active entry count, then wrap
// RL21 - External trigger synchronised, one-cycle events
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "wsp_regs.svh"
module wsp_player
(
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        ext_trig_in,
    output logic      [15:0] sample_out,
    output logic             sample_valid_out,
    output logic             sync_out
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    wsp_pkg::wsp_state_t st_reg;
    logic [4:0]          cfg_reg;
    logic [31:0]         rate_reg;
    wsp_pkg::wsp_cnt_t   cnt_reg;
    wsp_pkg::wsp_idx_t   tidx_reg;
    wsp_pkg::wsp_waddr_t waddr_reg;
    logic [31:0]         acc_reg;
    wsp_pkg::wsp_idx_t   ent_reg;
    wsp_pkg::wsp_rep_t   rep_reg;
    wsp_pkg::wsp_len_t   smp_reg;
    logic                pend_valid_reg;
    logic                pend_sync_reg;

    wsp_pkg::wsp_sel_t   tab_sel [0:1023];
    wsp_pkg::wsp_len_t   tab_len [0:1023];
    wsp_pkg::wsp_rep_t   tab_rep [0:1023];

    wsp_pkg::wsp_src_t   src;
    logic                wr_en;
    logic                exec_go;
    logic                stop_go;
    logic                man_go;
    logic                ext_pulse;
    logic                trig_ev;
    logic [32:0]         acc_sum;
    logic                tick;
    logic                step;
    wsp_pkg::wsp_sel_t   cur_sel;
    wsp_pkg::wsp_len_t   cur_len;
    wsp_pkg::wsp_rep_t   cur_rep;
    logic                cyc_last;
    logic                rep_last;
    logic                ent_last;
    logic                sync_next;
    logic                wave_we;
    wsp_pkg::wsp_smp_t   wave_rdata;
    logic [31:0]         rd_next;
    logic                err_next;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign src     = wsp_pkg::wsp_src_t'(cfg_reg[1:0]);
    assign wr_en   = ce_in & psel_in & penable_in & pready_out & pwrite_in;
    assign exec_go = wr_en & (paddr_in == `WSP_OFF_CTRL) & pwdata_in[`WSP_CTRL_EXEC];
    assign stop_go = wr_en & (paddr_in == `WSP_OFF_CTRL) & pwdata_in[`WSP_CTRL_STOP];
    assign man_go  = wr_en & (paddr_in == `WSP_OFF_CTRL) & pwdata_in[`WSP_CTRL_MTRIG];
    assign wave_we = wr_en & (paddr_in == `WSP_OFF_WDATA);

    // Read mux; table fields of the entry chosen by the index register appear at their own offsets
    always_comb
    begin
        rd_next  = 32'h00000000;
        err_next = 1'b0;
        unique case (paddr_in)
            `WSP_OFF_CTRL:  rd_next = 32'h00000000;
            `WSP_OFF_CFG:   rd_next = {27'h0000000, cfg_reg};
            `WSP_OFF_RATE:  rd_next = rate_reg;
            `WSP_OFF_COUNT: rd_next = {21'h000000, cnt_reg};
            `WSP_OFF_TIDX:  rd_next = {22'h000000, tidx_reg};
            `WSP_OFF_TSEL:  rd_next = {28'h0000000, tab_sel[tidx_reg]};
            `WSP_OFF_TLEN:  rd_next = {17'h00000, tab_len[tidx_reg]};
            `WSP_OFF_TREP:  rd_next = {16'h0000, tab_rep[tidx_reg]};
            `WSP_OFF_WADDR: rd_next = {14'h0000, waddr_reg};
            `WSP_OFF_WDATA: rd_next = 32'h00000000;
            `WSP_OFF_STAT:  rd_next = {6'h00, ent_reg, rep_reg[13:0], st_reg};
            default:        err_next = 1'b1;
        endcase
    end

    // Zero-wait answer: pready rises in the access phase
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h00000000;
            pslverr_out <= 1'b0;
        end
        else if (ce_in)
        begin
            pready_out  <= psel_in & ~penable_in;
            prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? rd_next : 32'h00000000;
            pslverr_out <= psel_in & ~penable_in & err_next;
        end
    end

    // Configuration registers
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            cfg_reg   <= `WSP_CFG_RST;
            rate_reg  <= `WSP_RATE_RST;
            cnt_reg   <= `WSP_COUNT_RST;
            tidx_reg  <= 10'h000;
            waddr_reg <= 18'h00000;
        end
        else if (wr_en)
        begin
            unique case (paddr_in)
                `WSP_OFF_CFG:   cfg_reg <= pwdata_in[4:0];
                // Clamp: above the clock rate the accumulator would run away
                `WSP_OFF_RATE:  rate_reg <= (pwdata_in > `WSP_CLK_HZ) ? `WSP_CLK_HZ : pwdata_in;
                `WSP_OFF_COUNT: cnt_reg <= (pwdata_in[10:0] > `WSP_COUNT_MAX) ?
                                           `WSP_COUNT_MAX : pwdata_in[10:0]; // RL20
                `WSP_OFF_TIDX:  tidx_reg <= pwdata_in[9:0];
                `WSP_OFF_WADDR: waddr_reg <= pwdata_in[17:0];
                // Auto-increment eases bulk waveform loading
                `WSP_OFF_WDATA: waddr_reg <= waddr_reg + 18'h00001;
                default:        cfg_reg <= cfg_reg;
            endcase
        end
    end

    // Sequence table, no reset: contents are lost with power
    always_ff @(posedge mclk_in)
    begin
        if (wr_en && paddr_in == `WSP_OFF_TSEL)
            tab_sel[tidx_reg] <= pwdata_in[3:0]; // RL1 RL19
        if (wr_en && paddr_in == `WSP_OFF_TLEN)
            tab_len[tidx_reg] <= pwdata_in[14:0]; // RL1
        if (wr_en && paddr_in == `WSP_OFF_TREP)
            tab_rep[tidx_reg] <= pwdata_in[15:0]; // RL1
    end

    // ------------------------------------------------------------------
    // Sample-rate tick and trigger
    // ------------------------------------------------------------------
    // Fractional accumulator gives any rate up to the clock rate, in samples per second
    assign acc_sum = {1'b0, acc_reg} + {1'b0, rate_reg};
    assign tick    = acc_sum >= {1'b0, `WSP_CLK_HZ}; // RL4 RL5

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            acc_reg <= 32'h00000000;
        else if (ce_in)
        begin
            if (exec_go)
                acc_reg <= 32'h00000000;
            else if (tick)
                acc_reg <= 32'(acc_sum - {1'b0, `WSP_CLK_HZ});
            else
                acc_reg <= acc_sum[31:0];
        end
    end

    wsp_trig_sync u_trig
    (
        .mclk_in    (mclk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .trig_in    (ext_trig_in),
        .falling_in (cfg_reg[`WSP_CFG_EDGE]),
        .pulse_out  (ext_pulse)
    );

    // Only the selected source counts; internal needs none
    assign trig_ev = (src == wsp_pkg::WSP_SRC_MAN && man_go) ||
                     (src == wsp_pkg::WSP_SRC_EXT && ext_pulse); // RL8 RL9

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    assign step     = ce_in & tick & (st_reg == wsp_pkg::WSP_PLAY);
    assign cur_sel  = tab_sel[ent_reg];
    assign cur_len  = tab_len[ent_reg];
    assign cur_rep  = tab_rep[ent_reg];
    // Compares tolerate zero fields, which act as one
    assign cyc_last = ({1'b0, smp_reg} + 16'h0001) >= {1'b0, cur_len};
    assign rep_last = ({1'b0, rep_reg} + 17'h00001) >= {1'b0, cur_rep};
    assign ent_last = ({1'b0, ent_reg} + 12'h001) >= {1'b0, cnt_reg};

    // State: stop beats execute, execute beats play
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            st_reg <= wsp_pkg::WSP_IDLE;
        else if (ce_in)
        begin
            if (stop_go)
                st_reg <= wsp_pkg::WSP_IDLE;
            else if (exec_go)
                st_reg <= (src == wsp_pkg::WSP_SRC_INT) ?
                          wsp_pkg::WSP_PLAY : wsp_pkg::WSP_WAIT; // RL6 RL7
            else
            begin
                unique case (st_reg)
                    wsp_pkg::WSP_IDLE: st_reg <= wsp_pkg::WSP_IDLE;
                    wsp_pkg::WSP_WAIT:
                    begin
                        if (trig_ev)
                            st_reg <= wsp_pkg::WSP_PLAY; // RL8 RL9 RL18
                    end
                    wsp_pkg::WSP_PLAY:
                    begin
                        // Mode only consulted for triggered sources
                        if (step && src != wsp_pkg::WSP_SRC_INT && cyc_last &&
                            (cfg_reg[`WSP_CFG_TMODE] || rep_last))
                            st_reg <= wsp_pkg::WSP_WAIT; // RL10 RL11 RL12
                    end
                    default: st_reg <= wsp_pkg::WSP_IDLE;
                endcase
            end
        end
    end

    // Sample, repeat and entry counters
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ent_reg <= 10'h000;
            rep_reg <= 16'h0000;
            smp_reg <= 15'h0000;
        end
        else if (ce_in)
        begin
            if (exec_go)
            begin
                ent_reg <= 10'h000;
                rep_reg <= 16'h0000;
                smp_reg <= 15'h0000;
            end
            else if (step)
            begin
                if (!cyc_last)
                    smp_reg <= smp_reg + 15'h0001; // RL3
                else
                begin
                    smp_reg <= 15'h0000;
                    if (!rep_last)
                        rep_reg <= rep_reg + 16'h0001; // RL3
                    else
                    begin
                        rep_reg <= 16'h0000;
                        ent_reg <= ent_last ? 10'h000 : ent_reg + 10'h001; // RL3 RL20
                    end
                end
            end
        end
    end

    // Sync level for the sample now being fetched; a zero count acts as one,
    // so the first unit of every entry still raises sync at the switch-over
    always_comb
    begin
        if (cfg_reg[`WSP_CFG_SMODE])
            sync_next = ({smp_reg, 1'b0} < {1'b0, cur_len}) | ~|smp_reg; // RL15
        else
            sync_next = ({rep_reg, 1'b0} < {1'b0, cur_rep}) | ~|rep_reg; // RL14 RL16 RL17
    end

    wsp_wave_mem u_wave
    (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .we_in     (wave_we),
        .waddr_in  (waddr_reg),
        .wdata_in  (pwdata_in[15:0]),
        .raddr_in  ({cur_sel, smp_reg[13:0]}), // RL2
        .rdata_out (wave_rdata)
    );

    // ------------------------------------------------------------------
    // Output stage, aligned to the one-cycle memory latency
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            pend_valid_reg   <= 1'b0;
            pend_sync_reg    <= 1'b0;
            sample_out       <= 16'h0000;
            sample_valid_out <= 1'b0;
            sync_out         <= 1'b0;
        end
        else if (ce_in)
        begin
            pend_valid_reg   <= step;
            if (step)
                pend_sync_reg <= sync_next;
            sample_valid_out <= pend_valid_reg; // RL4
            if (pend_valid_reg)
            begin
                sample_out <= wave_rdata;
                sync_out   <= pend_sync_reg; // RL16 RL18
            end
            else if (st_reg == wsp_pkg::WSP_IDLE)
                sync_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    property p_exec_starts;
        exec_go && !stop_go |=> st_reg != wsp_pkg::WSP_IDLE;
    endproperty
    a_exec_starts: assert property (p_exec_starts) else $error("execute did not start"); // RL6

    property p_int_free;
        ce_in && st_reg == wsp_pkg::WSP_PLAY && src == wsp_pkg::WSP_SRC_INT && !stop_go
        |=> st_reg == wsp_pkg::WSP_PLAY;
    endproperty
    a_int_free: assert property (p_int_free) else $error("internal source stopped"); // RL7

    property p_man_step;
        st_reg == wsp_pkg::WSP_WAIT && src == wsp_pkg::WSP_SRC_MAN && man_go &&
        !stop_go && !exec_go |=> st_reg == wsp_pkg::WSP_PLAY;
    endproperty
    a_man_step: assert property (p_man_step) else $error("manual trigger lost"); // RL8

    property p_ext_step;
        ce_in && st_reg == wsp_pkg::WSP_WAIT && src == wsp_pkg::WSP_SRC_EXT && ext_pulse &&
        !stop_go && !exec_go |=> st_reg == wsp_pkg::WSP_PLAY;
    endproperty
    a_ext_step: assert property (p_ext_step) else $error("external trigger lost"); // RL9

    property p_ext_once;
        ce_in && ext_pulse |=> !ext_pulse;
    endproperty
    a_ext_once: assert property (p_ext_once) else $error("trigger event too long"); // RL21

    property p_entry_mode;
        step && !cfg_reg[`WSP_CFG_TMODE] && cyc_last && !rep_last && !stop_go && !exec_go
        |=> st_reg == wsp_pkg::WSP_PLAY;
    endproperty
    a_entry_mode: assert property (p_entry_mode) else $error("entry mode paused early"); // RL11

    property p_cycle_mode;
        step && cfg_reg[`WSP_CFG_TMODE] && src != wsp_pkg::WSP_SRC_INT && cyc_last &&
        !stop_go && !exec_go |=> st_reg == wsp_pkg::WSP_WAIT;
    endproperty
    a_cycle_mode: assert property (p_cycle_mode) else $error("cycle mode did not pause"); // RL12

    property p_sync_rise;
        step && !cfg_reg[`WSP_CFG_SMODE] && smp_reg == 15'h0000 && rep_reg == 16'h0000
        ##1 ce_in |=> sync_out && sample_valid_out;
    endproperty
    a_sync_rise: assert property (p_sync_rise) else $error("sync not high at switch"); // RL16

    property p_sync_half;
        step && !cfg_reg[`WSP_CFG_SMODE] && {rep_reg, 1'b0} >= {1'b0, cur_rep}
        && rep_reg != 16'h0000 ##1 ce_in |=> !sync_out;
    endproperty
    a_sync_half: assert property (p_sync_half) else $error("sync held too long"); // RL17

    property p_wrap;
        step && cyc_last && rep_last && ent_last && !exec_go |=> ent_reg == 10'h000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("entry did not wrap"); // RL20

    c_pause: cover property (st_reg == wsp_pkg::WSP_PLAY ##1 st_reg == wsp_pkg::WSP_WAIT);
    c_ext: cover property (ext_pulse && st_reg == wsp_pkg::WSP_WAIT);
    c_sync: cover property (!sync_out ##1 sync_out);
endmodule

// ### testbench/wsp_far_end.sv
// Far-side model: sample sink and external trigger source
`timescale 1ns/1ps
module wsp_far_end
(
    input  wire logic        mclk_in,
    input  wire logic        valid_in,
    input  wire logic [15:0] sample_in,
    input  wire logic        sync_in,
    output logic             ext_trig_out
);
    // ----------------------------------------
    // Capture and trigger drive
    // ----------------------------------------
    logic [16:0] got[$];

    initial ext_trig_out = 1'b0;

    // Valid stays high for back-to-back samples at full rate, so each edge holding it is one sample
    always @(posedge mclk_in)
        if (valid_in === 1'b1)
            got.push_back({sync_in, sample_in});

    // Level held long enough for the two-stage synchroniser and a whole entry
    task automatic drive(input logic v);
        @(posedge mclk_in);
        ext_trig_out <= v;
        repeat (40) @(posedge mclk_in);
    endtask
endmodule

// ### testbench/tb.sv
// Self-checking bench for the waveform sequence player
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Signals, model state and instances
    // ----------------------------------------
    logic              mclk_in = 1'b0;
    logic              rst_in  = 1'b1;
    logic              ce      = 1'b1;
    logic              psel    = 1'b0;
    logic              pen     = 1'b0;
    logic              pwr     = 1'b0;
    logic [7:0]        pa      = 8'h00;
    logic [31:0]       pwd     = 32'h0;
    logic [31:0]       prd;
    logic [31:0]       rd;
    logic              prdy;
    logic              perr;
    logic              er;
    logic              vld;
    logic              sync;
    logic              trig;
    logic [15:0]       smp;
    logic [16:0]       exp_q[$];
    wsp_pkg::wsp_smp_t mem[16][4];
    int                sel[2]    = '{2, 5};
    int                len[2]    = '{3, 2};
    int                rep[2]    = '{2, 3};
    int                fails     = 0;
    int                cmp_count = 0;
    logic [31:0]       seed      = 32'h5546;

    initial forever #12.5 mclk_in = ~mclk_in;

    wsp_player dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .ext_trig_in(trig),
        .sample_out(smp), .sample_valid_out(vld), .sync_out(sync));

    wsp_far_end far (.mclk_in(mclk_in), .valid_in(vld), .sample_in(smp), .sync_in(sync),
        .ext_trig_out(trig));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tmo();
        fails++;
        $display("Error %0t: wait timed out", $time);
        give_verdict();
    endtask

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("Error %0t: register got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_smp(input logic [16:0] g, input logic [16:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("Error %0t: sync+sample got %h want %h", $time, g, e);
        end
    endtask

    // Request held until pready is seen high, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge mclk_in);
        pen <= 1'b1;
        do
        begin
            @(posedge mclk_in);
            n++;
        end
        while (prdy !== 1'b1 && n < 50);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 50)
            tmo();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_reg(rd, e);
    endtask

    task automatic wait_n(input int n);
        int k;
        k = 0;
        while (far.got.size() < n && k < 3000)
        begin
            @(posedge mclk_in);
            k++;
        end
        if (k >= 3000)
            tmo();
    endtask

    // Expected samples of one repetition; sync per entry half or per cycle half
    task automatic add(input int e, input int r, input logic cyc);
        for (int i = 0; i < len[e]; i++)
            exp_q.push_back({cyc ? (2 * i < len[e]) : (2 * r < rep[e]), mem[sel[e]][i]});
    endtask

    task automatic cmp_all();
        for (int i = 0; i < exp_q.size(); i++)
            chk_smp(far.got[i], exp_q[i]);
        far.got.delete();
        exp_q.delete();
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h000F4240);
        rdchk(8'h0C, 32'h1);
        wr(8'h0C, 32'h7FF);
        rdchk(8'h0C, 32'h400);
        apb(1'b0, 8'h2C, 32'h0);
        chk_reg({31'h0, er}, 32'h1);
        for (int e = 0; e < 2; e++)
        begin
            wr(8'h10, e);
            wr(8'h14, sel[e]);
            wr(8'h18, len[e]);
            wr(8'h1C, rep[e]);
            wr(8'h20, sel[e] << 14);
            for (int i = 0; i < len[e]; i++)
            begin
                mem[sel[e]][i] = 16'(xs());
                wr(8'h24, {16'h0, mem[sel[e]][i]});
            end
        end
        wr(8'h0C, 32'h2);
        wr(8'h08, 32'h02625A00);
        // Internal source with cycle trigger mode set: mode must be ignored
        wr(8'h04, 32'h04);
        wr(8'h00, 32'h1);
        for (int p = 0; p < 2; p++)
            for (int e = 0; e < 2; e++)
                for (int r = 0; r < rep[e]; r++)
                    add(e, r, 1'b0);
        wait_n(24);
        wr(8'h00, 32'h4);
        repeat (6) @(posedge mclk_in);
        cmp_all();
        // Manual source, cycle trigger and cycle sync
        wr(8'h04, 32'h15);
        wr(8'h00, 32'h1);
        repeat (20) @(posedge mclk_in);
        chk_reg(32'(far.got.size()), 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h00, 32'h2);
            repeat (30) @(posedge mclk_in);
        end
        chk_reg(32'(far.got.size()), 32'h8);
        add(0, 0, 1'b1);
        add(0, 1, 1'b1);
        add(1, 0, 1'b1);
        cmp_all();
        wr(8'h00, 32'h4);
        // External falling edge, entry trigger, slower rate
        far.drive(1'b1);
        wr(8'h08, 32'h01312D00);
        wr(8'h04, 32'h0A);
        wr(8'h00, 32'h1);
        far.drive(1'b0);
        // Edges while frozen must be lost: clock enable holds every flop
        @(posedge mclk_in);
        ce <= 1'b0;
        far.drive(1'b1);
        far.drive(1'b0);
        ce <= 1'b1;
        far.drive(1'b1);
        far.drive(1'b0);
        chk_reg(32'(far.got.size()), 32'hC);
        for (int e = 0; e < 2; e++)
            for (int r = 0; r < rep[e]; r++)
                add(e, r, 1'b0);
        cmp_all();
        // External rising edge, entry trigger: one rise plays entry 0
        wr(8'h04, 32'h02);
        wr(8'h00, 32'h1);
        far.drive(1'b1);
        chk_reg(32'(far.got.size()), 32'h6);
        add(0, 0, 1'b0);
        add(0, 1, 1'b0);
        cmp_all();
        give_verdict();
    end
endmodule
